// file: design/gprp_map.vh
// Register map, field positions, reset values and timing for the pin port
`ifndef GPRP_MAP_VH
`define GPRP_MAP_VH

// ==========================================================================
// Register indices on the index/data port
`define GPRP_NET_CTRL_IDX     8'h00
`define GPRP_PIN_DIR_IDX      8'h1e
`define GPRP_PIN_LVL_IDX      8'h1f

// ==========================================================================
// Field positions
`define GPRP_SW_RESET_BIT     0
`define GPRP_PHY_PD_BIT       0
`define GPRP_CFG_LSB          1
`define GPRP_CFG_MSB          3
`define GPRP_FIX_LSB          4
`define GPRP_FIX_MSB          6
`define GPRP_PHY_BASIC_MODE_CONTROL_PD_BIT      11
`define GPRP_EE_PHY_EN_BIT    8

// ==========================================================================
// Reset values
`define GPRP_CFG_DIR_RST      3'h0
`define GPRP_FIX_DIR_VAL      3'h7
`define GPRP_FIX_LVL_RST      3'h0
`define GPRP_CFG_LVL_RST      3'h0
`define GPRP_PHY_PD_RST       1'h1
`define GPRP_DIR_BIT0_VAL     1'h1

// ==========================================================================
// Timing: clock period and documented times in ns
`define GPRP_CLK_PERIOD_NS    10
`define GPRP_READY_NS         5000
`define GPRP_SW_RESET_NS      10000
`define GPRP_POR_HOLD_NS      20000000

`endif

// file: design/gprp_sync.v
// Three-flop input synchroniser with second/third agreement filter
`timescale 1ns/100ps
module gprp_sync #(
   parameter WIDTH = 3
) (
   // Clocking
   input wire             clk,
   input wire             rst_n,
   input wire             ce,
   // Data
   input wire [WIDTH-1:0] din,
   output reg [WIDTH-1:0] dout
);

   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   integer i;

   // ========================================================================
   // Chain; only stage2 reads stage1, the filter looks at stages 2 and 3
   always @(posedge clk) begin
      if (!rst_n) begin
         stage1 <= {WIDTH{1'b0}};
         stage2 <= {WIDTH{1'b0}};
         stage3 <= {WIDTH{1'b0}};
         dout   <= {WIDTH{1'b0}};
      end else if (ce) begin
         stage1 <= din;
         stage2 <= stage1;
         stage3 <= stage2;
         // Accept a change only once two samples agree, rejecting glitches
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (stage2[i] == stage3[i]) begin
               dout[i] <= stage3[i];
            end
         end
      end
   end

endmodule // gprp_sync

// file: design/gprp_top.v
// General pin port with PHY power-down and reset sequencing
`timescale 1ns/100ps
`include "gprp_map.vh"
module gprp_top #(
   // Strap count; the default width is arbitrary
   parameter STRAP_W = 4
) (
   // Clock, reset, clock enable
   input wire               CLK_SYS,
   input wire               RSTN,
   input wire               CE,
   // Host index/data port (synchronous to CLK_SYS)
   input wire               HOST_CMD,
   input wire               HOST_WR,
   input wire               HOST_RD,
   input wire [7:0]         HOST_DIN,
   output reg  [7:0]        HOST_DOUT,
   output wire              HOST_DOE,
   // Bus mode and straps
   input wire               MODE_8BIT,
   input wire [STRAP_W-1:0] STRAP_IN,
   output reg [STRAP_W-1:0] STRAP_LATCHED,
   // Configurable pins, three signals each
   input wire [2:0]         GP_CFG_IN,
   output reg [2:0]         GP_CFG_OUT,
   output reg [2:0]         GP_CFG_OE,
   // Fixed-output pins
   output reg [2:0]         GP_FIXED_OUT,
   // PHY control
   input wire [15:0]        PHY_PHY_BASIC_MODE_CONTROL,
   output reg               PHY_POWER_DOWN,
   output reg               TXRX_ENABLE,
   // EEPROM auto-load hand-off
   input wire               EE_WAKE_VALID,
   input wire [15:0]        EE_WAKE_WORD,
   output reg               EE_LOAD_START,
   // Status
   output reg               DEV_READY,
   output reg               SW_RESET_ACTIVE
);

   // ========================================================================
   // Cycle counts derived from documented times
   // Least time rounds up
   localparam integer READY_CYC =
      (`GPRP_READY_NS + `GPRP_CLK_PERIOD_NS - 1) / `GPRP_CLK_PERIOD_NS;
   // Longest time rounds down
   localparam integer SWRST_CYC =
      `GPRP_SW_RESET_NS / `GPRP_CLK_PERIOD_NS;
   // Wide enough for the longer of the two counts
   localparam integer CNT_W = 11;

   // Sequencer states, one-hot
   localparam [3:0] ST_WAIT  = 4'h1;
   localparam [3:0] ST_LOAD  = 4'h2;
   localparam [3:0] ST_RUN   = 4'h4;
   localparam [3:0] ST_SWRST = 4'h8;
   // Any other code falls back to the wait state

   // ========================================================================
   // State
   // Registers behind the index/data port
   reg [7:0]       index;
   reg [2:0]       cfg_dir;
   reg [2:0]       cfg_lvl;
   reg [2:0]       fix_lvl;
   reg             phy_pd;
   reg             sw_rst_bit;
   reg             strap_done;
   // Sequencer
   reg [3:0]       state;
   reg [3:0]       next_state;
   reg [CNT_W-1:0] cnt;
   reg [CNT_W-1:0] next_cnt;
   reg             host_rd_q;
   wire [2:0]      pin_in;
   wire            data_wr;
   wire            phy_basic_mode_control_pd;
   wire            pd_any;
   reg  [7:0]      rd_val;

   // Data port write; the index port is written with HOST_CMD low
   assign data_wr = HOST_WR & HOST_CMD;
   assign phy_basic_mode_control_pd = PHY_PHY_BASIC_MODE_CONTROL[`GPRP_PHY_BASIC_MODE_CONTROL_PD_BIT];
   // Either power-down source is enough on its own
   assign pd_any  = phy_pd | phy_basic_mode_control_pd;
   // Read data drives the bus for one cycle after a read strobe
   assign HOST_DOE = host_rd_q;

   // ========================================================================
   // Input pins cross in through the filtered synchroniser
   // Costs four cycles before a read sees a new level
   gprp_sync #(
      .WIDTH (3)
   ) u_sync (
      .clk   (CLK_SYS),
      .rst_n (RSTN),
      .ce    (CE),
      .din   (GP_CFG_IN),
      .dout  (pin_in)
   );

   // ========================================================================
   // Strap capture on the first enabled edge after reset release
   // Taken once, so later strap pin changes are ignored
   always @(posedge CLK_SYS) begin
      if (!RSTN) begin
         strap_done    <= 1'b0;
         STRAP_LATCHED <= {STRAP_W{1'b0}};
      end else if (CE && !strap_done) begin
         strap_done    <= 1'b1;
         STRAP_LATCHED <= STRAP_IN;
      end
   end

   // ========================================================================
   // Reset sequencer: ready delay, EEPROM load, software reset window
   // The counter runs only in the wait and window states
   always @* begin
      next_state = state;
      next_cnt   = cnt;
      case (state)
         ST_WAIT: begin
            // Ready only after the full delay from release
            if (cnt == READY_CYC[CNT_W-1:0] - 1'b1) begin
               next_state = ST_LOAD;
               next_cnt   = {CNT_W{1'b0}};
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         ST_LOAD: begin
            // Load engine answers with the wake-up word
            // No timeout: a loader that never answers stalls start-up
            if (EE_WAKE_VALID) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            // A one written to the control bit opens the window
            if (data_wr && index == `GPRP_NET_CTRL_IDX &&
                HOST_DIN[`GPRP_SW_RESET_BIT]) begin
               next_state = ST_SWRST;
               next_cnt   = {CNT_W{1'b0}};
            end
         end
         ST_SWRST: begin
            // Host clearing the bit ends the window early
            if (data_wr && index == `GPRP_NET_CTRL_IDX &&
                !HOST_DIN[`GPRP_SW_RESET_BIT]) begin
               next_state = ST_RUN;
            end else if (cnt == SWRST_CYC[CNT_W-1:0] - 1'b1) begin
               next_state = ST_RUN;
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         default: begin
            next_state = ST_WAIT;
            next_cnt   = {CNT_W{1'b0}};
         end
      endcase
   end

   // State register; CE low holds both state and count
   // A hardware reset in mid-window restarts the ready delay
   always @(posedge CLK_SYS) begin
      if (!RSTN) begin
         state <= ST_WAIT;
         cnt   <= {CNT_W{1'b0}};
      end else if (CE) begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   // ========================================================================
   // Host index and register writes
   // Software reset restores pin registers; the power-down bit survives it
   always @(posedge CLK_SYS) begin
      if (!RSTN) begin
         index      <= 8'h00;
         cfg_dir    <= `GPRP_CFG_DIR_RST;
         cfg_lvl    <= `GPRP_CFG_LVL_RST;
         fix_lvl    <= `GPRP_FIX_LVL_RST;
         phy_pd     <= `GPRP_PHY_PD_RST;
         sw_rst_bit <= 1'b0;
      end else if (CE) begin
         // Index port write selects the register for the data port
         if (HOST_WR && !HOST_CMD) begin
            index <= HOST_DIN;
         end
         if (state == ST_SWRST && next_state == ST_RUN) begin
            // Self-clear at the end of the window
            sw_rst_bit <= 1'b0;
            cfg_dir    <= `GPRP_CFG_DIR_RST;
            cfg_lvl    <= `GPRP_CFG_LVL_RST;
            fix_lvl    <= `GPRP_FIX_LVL_RST;
         end else if (data_wr && index == `GPRP_NET_CTRL_IDX) begin
            // Stored in any state; only RUN turns it into a window
            sw_rst_bit <= HOST_DIN[`GPRP_SW_RESET_BIT];
         end
         // Read-only direction bits are dropped on write
         if (data_wr && index == `GPRP_PIN_DIR_IDX) begin
            cfg_dir <= HOST_DIN[`GPRP_CFG_MSB:`GPRP_CFG_LSB];
         end
         // A host write wins over the auto-load in the same cycle
         if (data_wr && index == `GPRP_PIN_LVL_IDX) begin
            fix_lvl <= HOST_DIN[`GPRP_FIX_MSB:`GPRP_FIX_LSB];
            cfg_lvl <= HOST_DIN[`GPRP_CFG_MSB:`GPRP_CFG_LSB];
            phy_pd  <= HOST_DIN[`GPRP_PHY_PD_BIT];
         end else if (state == ST_LOAD && EE_WAKE_VALID) begin
            // Word bit set means PHY enabled, so the bit is inverted
            phy_pd <= ~EE_WAKE_WORD[`GPRP_EE_PHY_EN_BIT];
         end
      end
   end

   // ========================================================================
   // Read multiplexer
   always @* begin
      rd_val = 8'h00;
      if (!HOST_CMD) begin
         // Index port reads back the selected index
         rd_val = index;
      end else begin
         case (index)
            `GPRP_NET_CTRL_IDX: begin
               rd_val = {7'h00, sw_rst_bit};
            end
            `GPRP_PIN_DIR_IDX: begin
               // Upper direction bits are constant ones
               rd_val = {1'b0, `GPRP_FIX_DIR_VAL, cfg_dir,
                         `GPRP_DIR_BIT0_VAL};
            end
            `GPRP_PIN_LVL_IDX: begin
               // Input pins show the received level per bit
               rd_val = {1'b0, fix_lvl,
                         (cfg_dir & cfg_lvl) | (~cfg_dir & pin_in),
                         phy_pd};
            end
            default: begin
               // Unmapped registers read as zero
               rd_val = 8'h00;
            end
         endcase
      end
   end

   // Read data register; DOUT holds the last read until the next one
   // Data is taken at the strobe edge, so DOE and DOUT rise together
   always @(posedge CLK_SYS) begin
      if (!RSTN) begin
         HOST_DOUT <= 8'h00;
         host_rd_q <= 1'b0;
      end else if (CE) begin
         host_rd_q <= HOST_RD;
         if (HOST_RD) begin
            HOST_DOUT <= rd_val;
         end
      end
   end

   // ========================================================================
   // Pin drivers; enables and fixed levels are forced to zero outside 8-bit bus mode
   // Registered, so a write reaches the pins one edge after it lands
   always @(posedge CLK_SYS) begin
      if (!RSTN) begin
         GP_CFG_OUT   <= 3'h0;
         GP_CFG_OE    <= 3'h0;
         GP_FIXED_OUT <= 3'h0;
      end else if (CE) begin
         // Configurable level runs in both modes; the enables and the fixed levels are gated
         GP_CFG_OUT   <= cfg_lvl;
         GP_CFG_OE    <= MODE_8BIT ? cfg_dir : 3'h0;
         GP_FIXED_OUT <= MODE_8BIT ? fix_lvl : 3'h0;
      end
   end

   // ========================================================================
   // PHY power-down and data path gating
   always @(posedge CLK_SYS) begin
      if (!RSTN) begin
         PHY_POWER_DOWN  <= 1'b1;
         TXRX_ENABLE     <= 1'b0;
         DEV_READY       <= 1'b0;
         EE_LOAD_START   <= 1'b0;
         SW_RESET_ACTIVE <= 1'b0;
      end else if (CE) begin
         // Either source powers down; neither overrides the other
         PHY_POWER_DOWN  <= pd_any;
         // Clocks keep running; only the data path is gated
         TXRX_ENABLE     <= ~pd_any & (state == ST_RUN);
         // Load start pulses one cycle before ready rises
         DEV_READY       <= (state != ST_WAIT);
         EE_LOAD_START   <= (state == ST_WAIT) &&
                            (next_state == ST_LOAD);
         // Window status lags the sequencer by one cycle
         SW_RESET_ACTIVE <= (state == ST_SWRST);
      end
   end

endmodule // gprp_top

// file: verif/gprp_pins.sv
// Model of the outside circuitry on the configurable pins
`timescale 1ns/100ps
// ==========================================
// Pin resolver
module gprp_pins (
   // Pin side
   input  wire [2:0] oe,
   input  wire [2:0] out,
   input  wire [2:0] ext,
   output wire [2:0] pin
);
   // Device wins where it drives, else the outside level
   assign pin = (oe & out) | (~oe & ext);
endmodule // gprp_pins

// file: verif/gprp_sva.sv
// Assertion checker for the pin port, bound to the top
`timescale 1ns/100ps
// ==========================================
// Checker
module gprp_sva (
   // Clock and reset
   input wire        CLK_SYS,
   input wire        RSTN,
   input wire        CE,
   // Host port
   input wire        HOST_CMD,
   input wire        HOST_WR,
   input wire        HOST_RD,
   input wire [7:0]  HOST_DIN,
   input wire [7:0]  HOST_DOUT,
   input wire        HOST_DOE,
   // Pins and PHY
   input wire        MODE_8BIT,
   input wire [2:0]  GP_CFG_OE,
   input wire [2:0]  GP_FIXED_OUT,
   input wire [15:0] PHY_PHY_BASIC_MODE_CONTROL,
   input wire        PHY_POWER_DOWN,
   input wire        TXRX_ENABLE,
   input wire        SW_RESET_ACTIVE
);
   reg  [7:0]  idx;
   reg  [10:0] swr_len;
   wire        dwr = CE && HOST_WR && HOST_CMD;
   // Shadow index and window length; index is not decoded by the bench
   always @(posedge CLK_SYS) begin
      if (!RSTN) begin
         idx     <= 8'h00;
         swr_len <= 11'h000;
      end else if (CE) begin
         if (HOST_WR && !HOST_CMD) idx <= HOST_DIN;
         swr_len <= SW_RESET_ACTIVE ? swr_len + 11'h001 : 11'h000;
      end
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   // Data write then a quiet cycle, outputs settle one edge later
   sequence s_dir_wr;
      dwr && idx == 8'h1e && MODE_8BIT && !SW_RESET_ACTIVE
      ##1 !HOST_WR && MODE_8BIT && !SW_RESET_ACTIVE;
   endsequence
   sequence s_lvl_wr;
      dwr && idx == 8'h1f && MODE_8BIT && !SW_RESET_ACTIVE
      ##1 !HOST_WR && MODE_8BIT && !SW_RESET_ACTIVE;
   endsequence
   AST_READ_DOE: assert property (CE && HOST_RD |=> HOST_DOE)
      else $error("read gave no data strobe");
   AST_DIR_WR: assert property (s_dir_wr |=>
      GP_CFG_OE == $past(HOST_DIN[3:1], 2)) else $error("direction lost");
   AST_DIR_READ: assert property (CE && HOST_RD && HOST_CMD &&
      idx == 8'h1e |=> HOST_DOUT[7:4] == 4'h7 && HOST_DOUT[0])
      else $error("fixed direction bits wrong");
   AST_FIX_LVL: assert property (s_lvl_wr |=>
      GP_FIXED_OUT == $past(HOST_DIN[6:4], 2)) else $error("fixed level");
   AST_GATE: assert property (!MODE_8BIT ##1 !MODE_8BIT |->
      GP_FIXED_OUT == 3'h0 && GP_CFG_OE == 3'h0) else $error("mode gate");
   AST_RESET_PD: assert property (@(posedge CLK_SYS) disable iff (1'b0)
      CE && !RSTN |=> PHY_POWER_DOWN && !HOST_DOE &&
      GP_CFG_OE == 3'h0) else $error("reset values wrong");
   AST_PHY_BASIC_MODE_CONTROL_PD: assert property (PHY_PHY_BASIC_MODE_CONTROL[11] ##1 PHY_PHY_BASIC_MODE_CONTROL[11]
      |-> PHY_POWER_DOWN) else $error("control bit did not power down");
   AST_PD_TXRX: assert property (PHY_POWER_DOWN [*2] |->
      !TXRX_ENABLE) else $error("traffic enabled while powered down");
   AST_SWR_LEN: assert property (swr_len <= 11'h3e8)
      else $error("software reset too long");
   AST_SWR_ZERO: assert property (dwr && idx == 8'h00 &&
      !HOST_DIN[0] && SW_RESET_ACTIVE |=> ##1 !SW_RESET_ACTIVE)
      else $error("zero write did not end reset");
endmodule // gprp_sva

bind gprp_top gprp_sva u_sva (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CE(CE),
   .HOST_CMD(HOST_CMD), .HOST_WR(HOST_WR), .HOST_RD(HOST_RD),
   .HOST_DIN(HOST_DIN), .HOST_DOUT(HOST_DOUT), .HOST_DOE(HOST_DOE),
   .MODE_8BIT(MODE_8BIT), .GP_CFG_OE(GP_CFG_OE),
   .GP_FIXED_OUT(GP_FIXED_OUT), .PHY_PHY_BASIC_MODE_CONTROL(PHY_PHY_BASIC_MODE_CONTROL),
   .PHY_POWER_DOWN(PHY_POWER_DOWN), .TXRX_ENABLE(TXRX_ENABLE),
   .SW_RESET_ACTIVE(SW_RESET_ACTIVE));

// file: verif/gprp_top_bench.sv
// Self-checking bench for the pin port
`timescale 1ns/100ps
// ==========================================
// Bench
module gprp_top_bench;
   reg         clk_sys = 0, rstn = 0, cmd = 0, wr = 0, rd = 0;
   reg         mode = 1, ee_vld = 0;
   reg  [7:0]  din = 8'h00;
   reg  [3:0]  strap = 4'h9;
   reg  [2:0]  ext = 3'h5;
   reg  [15:0] phy_basic_mode_control = 16'h0000, ee_word = 16'h0100;
   wire [7:0]  dout;
   wire [3:0]  strap_l;
   wire [2:0]  pin, cout, coe, fout;
   wire        doe, pd, txrx, ee_start, ready, swr;
   integer     num_errors = 0, comparisons = 0, cyc = 0, t0;
   // Clock 100 MHz and cycle count since reset release
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) cyc <= rstn ? cyc + 1 : 0;
   gprp_top DUT (.CLK_SYS(clk_sys), .RSTN(rstn), .CE(1'b1),
      .HOST_CMD(cmd), .HOST_WR(wr), .HOST_RD(rd), .HOST_DIN(din),
      .HOST_DOUT(dout), .HOST_DOE(doe), .MODE_8BIT(mode),
      .STRAP_IN(strap), .STRAP_LATCHED(strap_l), .GP_CFG_IN(pin),
      .GP_CFG_OUT(cout), .GP_CFG_OE(coe), .GP_FIXED_OUT(fout),
      .PHY_PHY_BASIC_MODE_CONTROL(phy_basic_mode_control), .PHY_POWER_DOWN(pd), .TXRX_ENABLE(txrx),
      .EE_WAKE_VALID(ee_vld), .EE_WAKE_WORD(ee_word),
      .EE_LOAD_START(ee_start), .DEV_READY(ready),
      .SW_RESET_ACTIVE(swr));
   gprp_pins u_pins (.oe(coe), .out(cout), .ext(ext), .pin(pin));
   // Closing report
   task test_done;
      begin
         $display("errors %0d comparisons %0d", num_errors, comparisons);
         if (num_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task check(input [7:0] seen, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task tick(input integer k);
      repeat (k) @(negedge clk_sys);
   endtask
   // Give up when a wait ran out
   task bound(input ok);
      if (!ok) begin
         num_errors = num_errors + 1;
         $display("ERROR %0t: wait timed out", $time);
         test_done;
      end
   endtask
   // Index write then data write, back to back
   task iow(input [7:0] idx, input [7:0] val);
      begin
         tick(1); cmd = 0; wr = 1; din = idx;
         tick(1); cmd = 1; din = val;
         tick(1); wr = 0;
      end
   endtask
   // Index write then data read; answer lands one edge after strobe
   task ior(input [7:0] idx, input [7:0] exp);
      begin
         tick(1); cmd = 0; wr = 1; din = idx;
         tick(1); wr = 0; cmd = 1; rd = 1;
         tick(1); rd = 0;
         check(doe, 8'h01);
         check(dout, exp);
      end
   endtask
   // Main sequence
   initial begin
      tick(2); rstn = 1; // shortened hold
      tick(6);
      check(strap_l, 8'h09);
      check(pd, 8'h01);
      ior(8'h1e, 8'h71);
      ior(8'h1f, 8'h0b);
      iow(8'h20, 8'hff);
      ior(8'h20, 8'h00);
      while (!ee_start && cyc < 800) tick(1);
      bound(ee_start);
      check(cyc >= 499 && cyc <= 502, 8'h01);
      check(ready, 8'h00);
      tick(1);
      check(ready, 8'h01);
      check(ee_start, 8'h00);
      ee_vld = 1; tick(1); ee_vld = 0; tick(4);
      check(pd, 8'h00);
      check(txrx, 8'h01);
      ior(8'h1f, 8'h0a);
      phy_basic_mode_control = 16'h0800; tick(3);
      check(pd, 8'h01);
      check(txrx, 8'h00);
      phy_basic_mode_control = 16'h0000; tick(3);
      check(pd, 8'h00);
      iow(8'h1f, 8'h01); tick(2);
      check(pd, 8'h01);
      iow(8'h1f, 8'h00); tick(2);
      check(pd, 8'h00);
      iow(8'h1e, 8'hff);
      ior(8'h1e, 8'h7f);
      iow(8'h1f, 8'hda); tick(1);
      check(fout, 8'h05);
      check(cout, 8'h05);
      check(coe, 8'h07);
      ior(8'h1f, 8'h5a);
      iow(8'h1e, 8'h04); ext = 3'h2; tick(5);
      ior(8'h1f, 8'h50);
      ext = 3'h5; tick(5);
      ior(8'h1f, 8'h5a);
      mode = 0; tick(3);
      check({coe, fout}, 8'h00);
      mode = 1; tick(3);
      check(fout, 8'h05);
      iow(8'h00, 8'h01); t0 = cyc;
      tick(1);
      check(swr, 8'h01);
      check(txrx, 8'h00);
      ior(8'h00, 8'h01);
      while (swr && cyc - t0 < 1100) tick(1);
      bound(!swr);
      check(cyc - t0 >= 995 && cyc - t0 <= 1001, 8'h01);
      ior(8'h00, 8'h00);
      ior(8'h1e, 8'h71);
      ior(8'h1f, 8'h0a);
      iow(8'h00, 8'h01); tick(3);
      iow(8'h00, 8'h00); tick(1);
      check(swr, 8'h00);
      strap = 4'h6; rstn = 0; tick(2);
      check({pd, ready}, 8'h02);
      rstn = 1; tick(2);
      check(strap_l, 8'h06);
      ior(8'h1e, 8'h71);
      // Wake-up word with the enable bit clear keeps the PHY down
      ee_word = 16'h0000;
      while (!ee_start && cyc < 800) tick(1);
      bound(ee_start);
      ee_vld = 1; tick(1); ee_vld = 0; tick(4);
      check(pd, 8'h01);
      check(txrx, 8'h00);
      ior(8'h1f, 8'h0b);
      test_done;
   end
endmodule // gprp_top_bench
